// ---- verilog/ddspa_core.sv ----
// Profile-driven phase accumulator core with cosine output and clock-path settings.
// Assumes host writes buffered values synchronously to mclk; analog parts lie outside.
// Functional notes
// - Accumulator of 48 bits adds the active tuning word every clock.
// - Active phase offset is added to each phase sample before amplitude conversion.
// - Amplitude stage outputs cosine of offset phase, full range one turn.
// - One amplitude word per sample clock goes to the 14-bit converter.
// - Reference divider ratio selectable among 1, 2, 4 and 8.
// - Driver source selectable: undivided, divided reference, or feedback input.
// - Each detector input divider accepts integer ratios 1 through 16.
// - Three-bit field multiplies base pump current by 1 to 8.
// - Bits enable rise and fall surge, disable default surge, pick internal resistor.
// - Single-tone is the reset mode using active profile word and offset.
// - Eight profiles, each with 48-bit tuning word and 14-bit offset.
// - Profile-select pins carry the binary index of the active profile.
// - Tuning word and offset always come from the same profile.
// - Update input copies buffered data to active registers on next sync edge.
// - Sync clock is the system clock divided by four.
`timescale 1ns/10ps
module ddspa_core #(
  parameter int ACC_W = ddspa_pkg::ACC_W,
  parameter int PHASE_W = ddspa_pkg::PHASE_W,
  parameter int PROF_N = ddspa_pkg::PROF_N
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic profile_sel_bit0, // Profile index bit 0
  input wire logic profile_sel_bit1, // Profile index bit 1
  input wire logic profile_sel_bit2, // Profile index bit 2
  input wire logic io_update, // Transfer buffered settings, level
  input wire logic prof_wr_en, // Write one buffered profile
  input wire logic [2:0] prof_wr_idx, // Profile to write
  input wire logic [ACC_W-1:0] prof_wr_tune, // Buffered tuning word
  input wire logic [PHASE_W-1:0] prof_wr_pow, // Buffered phase offset
  input wire logic [1:0] buf_rf_div_code, // Buffered reference divider code
  input wire logic [3:0] buf_m_div_code, // Buffered reference detector divider, ratio-1
  input wire logic [3:0] buf_n_div_code, // Buffered feedback detector divider, ratio-1
  input wire logic [2:0] buf_cp_scale, // Buffered pump scale, multiplier-1
  input wire logic [1:0] buf_drv_src, // Buffered driver source
  input wire logic buf_core_clk_div, // Buffered core clock path: 1 = divided
  input wire logic [3:0] buf_surge, // Buffered {int_rset, no_default, fall_extra, rise_extra}
  output logic [ddspa_pkg::DAC_W-1:0] dac_word, // Amplitude word, offset binary
  output logic sync_clk_out, // Sync clock, mclk divided by four
  output logic [2:0] active_profile, // Sampled profile index
  output logic [3:0] rf_div_ratio, // Reference divider ratio 1/2/4/8
  output logic [4:0] m_div_ratio, // Reference detector divider ratio
  output logic [4:0] n_div_ratio, // Feedback detector divider ratio
  output logic [3:0] cp_mult, // Pump current multiplier
  output logic [1:0] drv_src_sel, // Driver source
  output logic core_clk_div, // Core clock path
  output logic rise_surge_en, // Extra rising-edge surge current
  output logic fall_surge_en, // Extra falling-edge surge current
  output logic default_surge_off, // Default surge disabled
  output logic int_rset_en // On-chip current-set resistor
);
  generate
    if (ACC_W < PHASE_W || PROF_N != 8 || PHASE_W != ddspa_pkg::PHASE_W) begin : g_chk
      $error("ddspa_core: unsupported parameters");
    end
  endgenerate

  // ==========================================================
  // Sync clock divider
  logic [ddspa_pkg::SYNC_CNT_W-1:0] div_cnt_reg;
  logic sync_tick;
  assign sync_tick = (div_cnt_reg == ddspa_pkg::SYNC_TICK_CNT);

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt_reg <= '0;
      sync_clk_out <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
      sync_clk_out <= ~div_cnt_reg[1];
    end
  end

  // ==========================================================
  // Update request: caught on any high level, served at the next sync edge
  logic upd_pend_reg;
  logic do_update;
  assign do_update = sync_tick && (upd_pend_reg || io_update);

  always_ff @(posedge mclk) begin
    if (rst) begin
      upd_pend_reg <= 1'b0;
    end else if (io_update) begin
      upd_pend_reg <= ~sync_tick; // A new request in the serving cycle is the one served
    end else if (sync_tick) begin
      upd_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Profile storage: buffered set and active set
  logic [ACC_W-1:0] buf_tune [PROF_N];
  logic [PHASE_W-1:0] buf_pow [PROF_N];
  logic [ACC_W-1:0] act_tune [PROF_N];
  logic [PHASE_W-1:0] act_pow [PROF_N];

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < PROF_N; i++) begin
        buf_tune[i] <= '0;
        buf_pow[i] <= '0;
      end
    end else if (prof_wr_en) begin
      buf_tune[prof_wr_idx] <= prof_wr_tune;
      buf_pow[prof_wr_idx] <= prof_wr_pow;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < PROF_N; i++) begin
        act_tune[i] <= '0;
        act_pow[i] <= '0;
      end
    end else if (do_update) begin
      for (int i = 0; i < PROF_N; i++) begin
        act_tune[i] <= buf_tune[i];
        act_pow[i] <= buf_pow[i];
      end
    end
  end

  // ==========================================================
  // Clock-path settings, applied with the same update
  always_ff @(posedge mclk) begin
    if (rst) begin
      rf_div_ratio <= 4'h1 << ddspa_pkg::RF_DIV_RST;
      m_div_ratio <= {1'b0, ddspa_pkg::MN_DIV_RST} + 5'h01;
      n_div_ratio <= {1'b0, ddspa_pkg::MN_DIV_RST} + 5'h01;
      cp_mult <= {1'b0, ddspa_pkg::CP_SCALE_RST} + 4'h1;
      drv_src_sel <= ddspa_pkg::DDSPA_DRV_UNDIV;
      core_clk_div <= 1'b0;
      {int_rset_en, default_surge_off, fall_surge_en, rise_surge_en} <= ddspa_pkg::SURGE_RST;
    end else if (do_update) begin
      rf_div_ratio <= 4'h1 << buf_rf_div_code;
      m_div_ratio <= {1'b0, buf_m_div_code} + 5'h01;
      n_div_ratio <= {1'b0, buf_n_div_code} + 5'h01;
      cp_mult <= {1'b0, buf_cp_scale} + 4'h1;
      // Unused code falls back to the undivided input rather than an undefined source
      drv_src_sel <= (buf_drv_src == 2'h3) ? ddspa_pkg::DDSPA_DRV_UNDIV : buf_drv_src;
      core_clk_div <= buf_core_clk_div;
      {int_rset_en, default_surge_off, fall_surge_en, rise_surge_en} <= buf_surge;
    end
  end

  // ==========================================================
  // Profile selection and single-tone data path
  logic [ACC_W-1:0] tune_act_reg;
  logic [PHASE_W-1:0] pow_act_reg;
  logic [ACC_W-1:0] acc_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic [ddspa_pkg::DAC_W-1:0] amp;

  always_ff @(posedge mclk) begin
    if (rst) begin
      active_profile <= '0;
    end else if (sync_tick) begin
      active_profile <= {profile_sel_bit2, profile_sel_bit1, profile_sel_bit0};
    end
  end

  // Both words read with one index so a profile is never split
  always_ff @(posedge mclk) begin
    if (rst) begin
      tune_act_reg <= '0;
      pow_act_reg <= '0;
    end else begin
      tune_act_reg <= act_tune[active_profile];
      pow_act_reg <= act_pow[active_profile];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_reg <= '0;
      phase_reg <= '0;
    end else begin
      acc_reg <= acc_reg + tune_act_reg;
      phase_reg <= acc_reg[ACC_W-1 -: PHASE_W] + pow_act_reg;
    end
  end

  ddspa_cos_lut #(
    .PHASE_W(PHASE_W),
    .DAC_W(ddspa_pkg::DAC_W)
  ) u_cos (
    .mclk(mclk),
    .rst(rst),
    .phase_in(phase_reg),
    .amp_out(amp)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      dac_word <= ddspa_pkg::DAC_MID;
    end else begin
      dac_word <= amp;
    end
  end

  // ==========================================================
  // Checks
  logic [ACC_W-1:0] sel_tune;
  logic [PHASE_W-1:0] sel_pow;
  assign sel_tune = act_tune[active_profile];
  assign sel_pow = act_pow[active_profile];

  AST_ACC_STEP: assert property (@(posedge mclk) disable iff (rst)
    ##1 acc_reg == $past(acc_reg) + $past(tune_act_reg))
    else $error("accumulator did not step by tuning word");
  AST_PHASE_OFFSET: assert property (@(posedge mclk) disable iff (rst)
    ##1 phase_reg == $past(acc_reg[ACC_W-1 -: PHASE_W]) + $past(pow_act_reg))
    else $error("phase offset not applied");
  AST_SAME_PROFILE: assert property (@(posedge mclk) disable iff (rst)
    ##1 (tune_act_reg == $past(sel_tune)) && (pow_act_reg == $past(sel_pow)))
    else $error("tuning word and offset from different profiles");
  AST_SYNC_PERIOD: assert property (@(posedge mclk) disable iff (rst)
    $rose(sync_clk_out) |-> ##1 sync_clk_out ##1 !sync_clk_out ##1 !sync_clk_out ##1 $rose(sync_clk_out))
    else $error("sync clock is not divide by four");
  AST_PROF_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
    !sync_tick |=> $stable(active_profile))
    else $error("profile changed outside a sync edge");
  AST_PROF_PINS: assert property (@(posedge mclk) disable iff (rst)
    sync_tick |=> active_profile == $past({profile_sel_bit2, profile_sel_bit1, profile_sel_bit0}))
    else $error("profile index not taken from pins");
  AST_UPDATE_SYNC: assert property (@(posedge mclk) disable iff (rst)
    (io_update && !sync_tick) |-> ##[1:4] (sync_tick && upd_pend_reg))
    else $error("update not served at next sync edge");
  AST_CP_MULT: assert property (@(posedge mclk) disable iff (rst)
    do_update |=> cp_mult == $past(buf_cp_scale) + 4'h1)
    else $error("pump multiplier wrong");
  AST_RF_RATIO: assert property (@(posedge mclk) disable iff (rst)
    $onehot(rf_div_ratio) && (rf_div_ratio <= 4'h8))
    else $error("reference divider ratio illegal");
  AST_MN_RANGE: assert property (@(posedge mclk) disable iff (rst)
    do_update |=> (m_div_ratio == {1'b0, $past(buf_m_div_code)} + 5'h01) &&
      (n_div_ratio == {1'b0, $past(buf_n_div_code)} + 5'h01))
    else $error("detector divider ratio wrong");
  AST_HOLD_NO_UPDATE: assert property (@(posedge mclk) disable iff (rst)
    !do_update |=> $stable(cp_mult) && $stable(drv_src_sel) && $stable(rise_surge_en))
    else $error("settings changed without an update");
  AST_DAC_PIPE: assert property (@(posedge mclk) disable iff (rst)
    ##1 dac_word == $past(amp))
    else $error("amplitude word not delivered");
endmodule

// ---- pkg/ddspa_pkg.sv ----
// Shared constants for the profile-driven phase accumulator core.
// Assumes a single synchronous clock domain (mclk, 50 MHz).
package ddspa_pkg;
  // ==========================================================
  // Widths and counts
  localparam int ACC_W = 48;
  localparam int PHASE_W = 14;
  localparam int DAC_W = 14;
  localparam int PROF_N = 8;
  localparam int PROF_SEL_W = 3;
  localparam int LUT_IDX_W = 5;
  localparam int SYNC_CNT_W = 2;
  localparam logic [SYNC_CNT_W-1:0] SYNC_TICK_CNT = 2'h0;
  localparam int CLK_PERIOD_NS = 20;
  // ==========================================================
  // Field widths and reset values of clock-path settings
  localparam int RF_DIV_W = 2;
  localparam int MN_DIV_W = 4;
  localparam int CP_SCALE_W = 3;
  localparam logic [RF_DIV_W-1:0] RF_DIV_RST = 2'h0;
  localparam logic [MN_DIV_W-1:0] MN_DIV_RST = 4'h0;
  localparam logic [CP_SCALE_W-1:0] CP_SCALE_RST = 3'h0;
  localparam logic [3:0] SURGE_RST = 4'h0;
  localparam logic [DAC_W-1:0] DAC_MID = 14'h2000;
  // ==========================================================
  // Driver source selection
  typedef enum logic [1:0] {
    DDSPA_DRV_UNDIV = 2'b00,
    DDSPA_DRV_DIV = 2'b01,
    DDSPA_DRV_FEEDBACK = 2'b10
  } ddspa_drv_src_t;
endpackage

// ---- verilog/ddspa_cos_lut.sv ----
// Phase-to-amplitude stage: quarter-wave cosine table, offset-binary output.
// Assumes phase arrives registered; adds one cycle of latency.
`timescale 1ns/10ps
module ddspa_cos_lut #(
  parameter int PHASE_W = ddspa_pkg::PHASE_W,
  parameter int DAC_W = ddspa_pkg::DAC_W
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [PHASE_W-1:0] phase_in, // Offset phase, full range = one turn
  output logic [DAC_W-1:0] amp_out // Amplitude word
);
  localparam int IW = ddspa_pkg::LUT_IDX_W;
  // ==========================================================
  // Table of 8191*cos((i+0.5)*pi/64); half-step offset keeps quadrants symmetric
  localparam logic [12:0] COS_TAB [0:31] = '{
    13'h1FFD, 13'h1FE9, 13'h1FC1, 13'h1F86, 13'h1F38, 13'h1ED6, 13'h1E62, 13'h1DDA,
    13'h1D40, 13'h1C94, 13'h1BD7, 13'h1B08, 13'h1A29, 13'h1939, 13'h183A, 13'h172C,
    13'h1610, 13'h14E6, 13'h13AF, 13'h126C, 13'h111E, 13'h0FC5, 13'h0E63, 13'h0CF7,
    13'h0B84, 13'h0A09, 13'h0889, 13'h0703, 13'h0578, 13'h03EB, 13'h025B, 13'h00C9};

  generate
    if (PHASE_W < IW + 2 || DAC_W != 14) begin : g_chk
      $error("ddspa_cos_lut: unsupported widths");
    end
  endgenerate

  logic [1:0] quad;
  logic [IW-1:0] idx;
  logic [12:0] mag;
  logic neg;

  // Quadrant folding: cos is mirrored in q1/q3 and negated in q1/q2
  always_comb begin
    quad = phase_in[PHASE_W-1 -: 2];
    idx = phase_in[PHASE_W-3 -: IW];
    mag = (quad[0]) ? COS_TAB[~idx] : COS_TAB[idx];
    neg = quad[1] ^ quad[0];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      amp_out <= ddspa_pkg::DAC_MID;
    end else begin
      amp_out <= neg ? ddspa_pkg::DAC_MID - {1'b0, mag} : ddspa_pkg::DAC_MID + {1'b0, mag};
    end
  end

  AST_PEAK_AT_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (phase_in[PHASE_W-1 -: IW+2] == '0) |=> (amp_out == 14'h3FFD))
    else $error("cosine peak missing at zero phase");
endmodule

// ---- tb/ddspa_dac_model.sv ----
// ==========================================================
// Converter-side model: takes one amplitude word on every clock.
// Assumes the core drives dac_word from a register on mclk.
`timescale 1ns/10ps
module ddspa_dac_model (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [ddspa_pkg::DAC_W-1:0] dac_word, // Word from the core
  output logic [ddspa_pkg::DAC_W-1:0] held_word, // Last word converted
  output logic [31:0] sample_cnt // Words taken since reset
);
  // One conversion per clock, no gaps, no hold-off
  always_ff @(posedge mclk) begin
    if (rst) begin
      held_word <= ddspa_pkg::DAC_MID;
      sample_cnt <= 32'h0;
    end else begin
      held_word <= dac_word;
      sample_cnt <= sample_cnt + 32'h1;
    end
  end
endmodule

// ---- tb/test_ddspa_core.sv ----
// ==========================================================
// Self-checking bench for the phase accumulator core; bench plays the host.
// Assumes inputs change 1 ns after the rising edge of mclk.
`timescale 1ns/10ps
module test_ddspa_core;
  logic mclk, rst, io_update, prof_wr_en, buf_core_clk_div, sync_clk_out, core_clk_div;
  logic rise_surge_en, fall_surge_en, default_surge_off, int_rset_en;
  logic [2:0] prof_wr_idx, buf_cp_scale, active_profile, pins;
  logic [47:0] prof_wr_tune;
  logic [13:0] prof_wr_pow, dac_word, held_word, a, b;
  logic [1:0] buf_rf_div_code, buf_drv_src, drv_src_sel;
  logic [3:0] buf_m_div_code, buf_n_div_code, buf_surge, rf_div_ratio, cp_mult;
  logic [4:0] m_div_ratio, n_div_ratio;
  logic [31:0] sample_cnt;
  logic [13:0] pows [8];
  int err_count, n_compared, seed, cycles, i, hi;
  ddspa_core u_dut (.mclk(mclk), .rst(rst), .profile_sel_bit0(pins[0]), .profile_sel_bit1(pins[1]),
    .profile_sel_bit2(pins[2]), .io_update(io_update), .prof_wr_en(prof_wr_en), .prof_wr_idx(prof_wr_idx),
    .prof_wr_tune(prof_wr_tune), .prof_wr_pow(prof_wr_pow), .buf_rf_div_code(buf_rf_div_code),
    .buf_m_div_code(buf_m_div_code), .buf_n_div_code(buf_n_div_code), .buf_cp_scale(buf_cp_scale),
    .buf_drv_src(buf_drv_src), .buf_core_clk_div(buf_core_clk_div), .buf_surge(buf_surge),
    .dac_word(dac_word), .sync_clk_out(sync_clk_out), .active_profile(active_profile),
    .rf_div_ratio(rf_div_ratio), .m_div_ratio(m_div_ratio), .n_div_ratio(n_div_ratio), .cp_mult(cp_mult),
    .drv_src_sel(drv_src_sel), .core_clk_div(core_clk_div), .rise_surge_en(rise_surge_en),
    .fall_surge_en(fall_surge_en), .default_surge_off(default_surge_off), .int_rset_en(int_rset_en));
  ddspa_dac_model u_dac (.mclk(mclk), .rst(rst), .dac_word(dac_word), .held_word(held_word),
    .sample_cnt(sample_cnt));
  // ==========================================================
  // Clock, timeout and shared tasks
  initial begin
    mclk = 1'b0;
    forever #(ddspa_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Stops just after the edge where the sync clock rises
  task automatic to_sync();
    logic prev;
    prev = sync_clk_out;
    step(1);
    for (int k = 0; k < 8 && !(sync_clk_out === 1'b1 && prev === 1'b0); k++) begin
      prev = sync_clk_out;
      step(1);
    end
  endtask
  task automatic update();
    io_update = 1'b1;
    step(4);
    io_update = 1'b0;
  endtask
  task automatic wr_prof(input logic [2:0] idx, input logic [47:0] word, input logic [13:0] pow);
    prof_wr_en = 1'b1;
    prof_wr_idx = idx;
    prof_wr_tune = word;
    prof_wr_pow = pow;
    step(1);
    // Strobe low for one edge so back-to-back writes never retoggle it in one time step
    prof_wr_en = 1'b0;
    step(1);
  endtask
  task automatic sel(input logic [2:0] p);
    pins = p;
  endtask
  // Full-turn cosine of 7-bit phase resolution, offset binary around midscale
  function automatic logic [13:0] cos_exp(input logic [6:0] k);
    real r;
    int v;
    r = 8191.0 * $cos((real'(k) + 0.5) * 3.14159265358979 / 64.0);
    v = $rtoi(r < 0.0 ? r - 0.5 : r + 0.5);
    return 14'(8192 + v);
  endfunction
  // Input clock rates are not modelled, so every divider code is a legal host choice
  task automatic set_bufs(input logic [15:0] r);
    {buf_rf_div_code, buf_m_div_code, buf_n_div_code, buf_cp_scale, buf_drv_src, buf_core_clk_div} = r[15:0];
    buf_surge = r[3:0] ^ r[15:12];
  endtask
  function automatic logic [63:0] exp_cfg();
    return {buf_rf_div_code == 2'h3 ? 4'h8 : 4'h1 << buf_rf_div_code, 5'(buf_m_div_code) + 5'h01,
      5'(buf_n_div_code) + 5'h01, 4'(buf_cp_scale) + 4'h1, buf_drv_src == 2'h3 ? 2'h0 : buf_drv_src,
      buf_core_clk_div, buf_surge};
  endfunction
  function automatic logic [63:0] seen_cfg();
    return {rf_div_ratio, m_div_ratio, n_div_ratio, cp_mult, drv_src_sel, core_clk_div,
      int_rset_en, default_surge_off, fall_surge_en, rise_surge_en};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    seed = 49;
    {rst, pins, io_update, prof_wr_en, prof_wr_idx, prof_wr_tune, prof_wr_pow} = '0;
    set_bufs(16'h0000);
    rst = 1'b1;
    step(10);
    rst = 1'b0;
    check("reset dac and profile", {dac_word, active_profile, held_word}, {14'h2000, 3'h0, 14'h2000});
    check("reset settings", seen_cfg(), exp_cfg());
    $display("test reset done");
    hi = 0;
    for (i = 0; i < 8; i++) begin
      step(1);
      hi += int'(sync_clk_out);
    end
    check("sync clock high count", 64'(hi), 64'd4);
    $display("test sync clock done");
    for (i = 0; i < 8; i++) begin
      pows[i] = 14'($random(seed));
      wr_prof(3'(i), 48'h0, pows[i]);
    end
    update();
    for (i = 7; i >= 0; i--) begin
      sel(3'(i));
      step(12);
      check("active profile", 64'(active_profile), 64'(i));
      check("dac per profile", 64'(dac_word), 64'(cos_exp(pows[i][13:7])));
    end
    $display("test profiles done");
    to_sync();
    sel(3'h5);
    step(3);
    check("pins held off", 64'(active_profile), 64'h0);
    step(1);
    check("pins sampled", 64'(active_profile), 64'h5);
    $display("test profile sampling done");
    for (i = 0; i < 10; i++) begin
      to_sync();
      set_bufs(i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : 16'($random(seed)));
      io_update = 1'b1;
      step(3);
      io_update = 1'b0;
      if (i > 0) check("settings before sync edge", seen_cfg() !== exp_cfg(), 64'h1);
      step(1);
      check("settings after sync edge", seen_cfg(), exp_cfg());
    end
    $display("test settings done");
    for (i = 1; i <= 2; i++) begin
      wr_prof(3'h6, 48'h8000_0000_0000 >> (i - 1), 14'($random(seed)));
      sel(3'h6);
      update();
      step(12);
      repeat (3) begin
        a = dac_word;
        step(1);
        check("converter sample", 64'(held_word), 64'(a));
        if (i > 1) step(i - 1);
        b = dac_word;
        check("half turn apart", 64'({1'b0, a} + {1'b0, b}), 64'h4000);
      end
    end
    // Ten edges saw reset high; every later edge must carry one converted word
    check("converter count", 64'(sample_cnt), 64'(cycles - 10));
    $display("test accumulator done");
    tally_and_finish();
  end
endmodule
